// file: tmr_top.sv
// Purpose: 16-bit timer/counter control, clock select and input capture
// Assumes: AHB-Lite slave, single word transfers, hclk is the I/O clock
// Notes:   Reads take one wait state, writes none; response always OKAY
// Operation
// - Waveform mode from control bytes A and B
// - Mode 0 counts to 0xFFFF, overflow at MAX
// - Modes 1-3 phase correct, fixed TOP
// - Fast PWM modes update and overflow at TOP
// - CTC modes 4, 12; mode 13 reserved
// - Modes 8, 9 update and overflow at BOTTOM
// - Filter needs four equal capture samples
// - Filter delays capture by four cycles
// - Edge select: zero falling, one rising
// - Capture copies counter, sets capture flag
// - Capture disabled when capture sets TOP
// - Clock select stops or picks prescaler tap
// - First timer codes 6, 7 use external pin
// - External pin counts even when driven
// - Second timer codes 6, 7 divide 16, 32
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module tmr_top #(
	parameter bit SECOND_TIMER = 1'b0
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        capture_pin,
	input  wire logic        external_clock_pin,
	output logic             overflow_flag,
	output logic             capture_flag
);
	import tmr_pkg::*;

	// Bus state
	tmr_bus_type    bus_q, bus_d;
	logic [31:0]    hrdata_q, hrdata_d;
	logic           hready_q, hready_d;
	// Control and data registers
	logic [1:0]     waveform_mode_low_q, waveform_mode_low_d;
	tmr_ctrl_b_type ctrl_b_q, ctrl_b_d;
	logic [15:0]    cnt_q, cnt_d;
	logic [15:0]    cmp_a_buf_q, cmp_a_buf_d, cmp_b_buf_q, cmp_b_buf_d;
	logic [15:0]    cmp_a_q, cmp_a_d, cmp_b_q, cmp_b_d;
	logic [15:0]    capture_register_q, capture_register_d;
	logic           ovf_q, ovf_d, cap_q, cap_d;
	tmr_dir_type    dir_q, dir_d;
	logic [9:0]     pre_q, pre_d;
	logic           ext_prev_q, ext_prev_d, cap_prev_q, cap_prev_d;
	// Decoded control
	tmr_mode_type   waveform_mode;
	tmr_event_type  upd_at, ovf_at;
	logic [15:0]    top_v;
	logic           dual, cap_top, tick, at_top, at_bot;
	logic           ext_lvl, cap_lvl, cap_ev, ovf_ev, upd_ev;
	logic           wr_go, wr_cnt, wr_cap;
	logic [31:0]    rd_mux;

	// Synchronise the external clock pin, never filtered
	tmr_sync_filter u_ext_sync (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.pin       (external_clock_pin),
		.filter_en (1'b0),
		.level     (ext_lvl)
	);

	// Synchronise and optionally filter the capture pin
	tmr_sync_filter u_cap_sync (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.pin       (capture_pin),
		.filter_en (ctrl_b_q.noise_en),
		.level     (cap_lvl)
	);

	// Mode decode: TOP source, update and overflow moments
	always_comb begin
		waveform_mode = tmr_mode_type'({ctrl_b_q.waveform_mode_high,
			waveform_mode_low_q});
		top_v  = TOP_MAX;
		dual   = 1'b0;
		upd_at = EV_NOW;
		ovf_at = EV_MAX;
		case (waveform_mode)
			MODE_PC8, MODE_PC9, MODE_PC10: begin
				top_v  = (waveform_mode == MODE_PC8) ? TOP_8BIT :
					(waveform_mode == MODE_PC9) ? TOP_9BIT : TOP_10BIT;
				dual   = 1'b1;
				upd_at = EV_TOP;
				ovf_at = EV_BOTTOM;
			end
			MODE_CTC_CMP: top_v = cmp_a_q;
			MODE_CTC_CAP: top_v = capture_register_q;
			MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_FAST_CAP,
			MODE_FAST_CMP: begin
				top_v  = (waveform_mode == MODE_FAST8) ? TOP_8BIT :
					(waveform_mode == MODE_FAST9) ? TOP_9BIT :
					(waveform_mode == MODE_FAST10) ? TOP_10BIT :
					(waveform_mode == MODE_FAST_CAP) ? capture_register_q
					: cmp_a_q;
				upd_at = EV_TOP;
				ovf_at = EV_TOP;
			end
			MODE_PFC_CAP, MODE_PFC_CMP: begin
				top_v  = (waveform_mode == MODE_PFC_CAP) ?
					capture_register_q : cmp_a_q;
				dual   = 1'b1;
				upd_at = EV_BOTTOM;
				ovf_at = EV_BOTTOM;
			end
			MODE_PC_CAP, MODE_PC_CMP: begin
				top_v  = (waveform_mode == MODE_PC_CAP) ?
					capture_register_q : cmp_a_q;
				dual   = 1'b1;
				upd_at = EV_TOP;
				ovf_at = EV_BOTTOM;
			end
			default: top_v = TOP_MAX;
		endcase
		cap_top = (waveform_mode == MODE_PFC_CAP) ||
			(waveform_mode == MODE_PC_CAP) ||
			(waveform_mode == MODE_CTC_CAP) ||
			(waveform_mode == MODE_FAST_CAP);
	end

	// Clock source select: prescaler taps or external pin edges
	always_comb begin
		pre_d      = pre_q + PRE_ONE;
		ext_prev_d = ext_lvl;
		case (ctrl_b_q.clock_select)
			CS_STOP:    tick = 1'b0;
			CS_DIV1:    tick = 1'b1;
			CS_DIV8:    tick = (pre_q & PRE_DIV8) == PRE_DIV8;
			CS_DIV64:   tick = (pre_q & PRE_DIV64) == PRE_DIV64;
			CS_DIV256:  tick = (pre_q & PRE_DIV256) == PRE_DIV256;
			CS_DIV1024: tick = (pre_q & PRE_DIV1024) == PRE_DIV1024;
			CS_ALT6:    tick = SECOND_TIMER ?
				((pre_q & PRE_DIV16) == PRE_DIV16) :
				(ext_prev_q && !ext_lvl);
			CS_ALT7:    tick = SECOND_TIMER ?
				((pre_q & PRE_DIV32) == PRE_DIV32) :
				(!ext_prev_q && ext_lvl);
			default:    tick = 1'b0;
		endcase
	end

	// Bus address phase decode and read mux
	always_comb begin
		wr_go  = bus_q.wr && bus_q.ok;
		wr_cnt = wr_go && (bus_q.idx == ADDR_COUNT[IDX_MSB:IDX_LSB]);
		wr_cap = wr_go && (bus_q.idx == ADDR_CAPTURE[IDX_MSB:IDX_LSB]);
		bus_d  = '0;
		if (hsel && htrans[1] && hready) begin
			bus_d.wr  = hwrite;
			bus_d.rd  = !hwrite;
			bus_d.ok  = (haddr[31:IDX_MSB+1] == '0) &&
				(haddr[IDX_MSB:IDX_LSB] <= ADDR_FLAGS[IDX_MSB:IDX_LSB]);
			bus_d.idx = haddr[IDX_MSB:IDX_LSB];
		end
		hready_d = !bus_d.rd;
		rd_mux   = '0;
		case ({3'b000, bus_q.idx, 2'b00})
			ADDR_CTRL_A:  rd_mux[1:0] = waveform_mode_low_q;
			ADDR_CTRL_B:  rd_mux[7:0] = ctrl_b_q;
			ADDR_COUNT:   rd_mux[15:0] = cnt_q;
			ADDR_CMP_A:   rd_mux[15:0] = cmp_a_buf_q;
			ADDR_CMP_B:   rd_mux[15:0] = cmp_b_buf_q;
			ADDR_CAPTURE: rd_mux[15:0] = capture_register_q;
			ADDR_FLAGS: begin
				rd_mux[FLG_OVF] = ovf_q;
				rd_mux[FLG_CAP] = cap_q;
			end
			default:      rd_mux = '0;
		endcase
		hrdata_d = bus_q.rd ? rd_mux : hrdata_q;
	end

	// Counting sequence, compare buffers, capture and flags
	always_comb begin
		at_top  = cnt_q == top_v;
		at_bot  = cnt_q == CNT_BOTTOM;
		cnt_d   = cnt_q;
		dir_d   = dual ? dir_q : DIR_UP;
		ovf_ev  = 1'b0;
		if (tick) begin
			if (!dual) begin
				cnt_d = at_top ? CNT_BOTTOM : cnt_q + CNT_ONE;
			end else if (dir_q == DIR_UP) begin
				dir_d = at_top ? DIR_DOWN : DIR_UP;
				cnt_d = at_top ? cnt_q - CNT_ONE : cnt_q + CNT_ONE;
			end else begin
				dir_d = at_bot ? DIR_UP : DIR_DOWN;
				cnt_d = at_bot ? cnt_q + CNT_ONE : cnt_q - CNT_ONE;
			end
			case (ovf_at)
				EV_MAX:    ovf_ev = cnt_q == TOP_MAX;
				EV_TOP:    ovf_ev = at_top;
				EV_BOTTOM: ovf_ev = at_bot && dir_q == DIR_DOWN;
				default:   ovf_ev = 1'b0;
			endcase
		end
		case (upd_at)
			EV_TOP:    upd_ev = tick && at_top;
			EV_BOTTOM: upd_ev = tick && at_bot;
			default:   upd_ev = 1'b1;
		endcase
		cmp_a_d = upd_ev ? cmp_a_buf_q : cmp_a_q;
		cmp_b_d = upd_ev ? cmp_b_buf_q : cmp_b_q;
		// Capture edge qualification
		cap_prev_d = cap_lvl;
		cap_ev = (ctrl_b_q.edge_rise ? (!cap_prev_q && cap_lvl) :
			(cap_prev_q && !cap_lvl)) && !cap_top;
		capture_register_d = cap_ev ? cnt_q : capture_register_q;
		// Software writes
		waveform_mode_low_d = waveform_mode_low_q;
		ctrl_b_d    = ctrl_b_q;
		cmp_a_buf_d = cmp_a_buf_q;
		cmp_b_buf_d = cmp_b_buf_q;
		ovf_d = ovf_q;
		cap_d = cap_q;
		if (wr_go) begin
			case ({3'b000, bus_q.idx, 2'b00})
				ADDR_CTRL_A: waveform_mode_low_d = hwdata[1:0];
				ADDR_CTRL_B: begin
					ctrl_b_d      = hwdata[7:0];
					ctrl_b_d.rsvd = 1'b0;
				end
				ADDR_COUNT:   cnt_d = hwdata[15:0];
				ADDR_CMP_A:   cmp_a_buf_d = hwdata[15:0];
				ADDR_CMP_B:   cmp_b_buf_d = hwdata[15:0];
				ADDR_CAPTURE: capture_register_d = hwdata[15:0];
				ADDR_FLAGS: begin
					ovf_d = ovf_q && !hwdata[FLG_OVF];
					cap_d = cap_q && !hwdata[FLG_CAP];
				end
				default: ovf_d = ovf_q;
			endcase
		end
		// Hardware set wins over a same-cycle clear
		if (ovf_ev) begin
			ovf_d = 1'b1;
		end
		if (cap_ev) begin
			cap_d = 1'b1;
			capture_register_d = cnt_q;
		end
	end

	// Register all state; ce low freezes everything
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_q               <= '0;
			hrdata_q            <= '0;
			hready_q            <= 1'b1;
			waveform_mode_low_q <= CTRL_RST[1:0];
			ctrl_b_q            <= CTRL_RST;
			cnt_q               <= WORD_RST;
			cmp_a_buf_q         <= WORD_RST;
			cmp_b_buf_q         <= WORD_RST;
			cmp_a_q             <= WORD_RST;
			cmp_b_q             <= WORD_RST;
			capture_register_q  <= WORD_RST;
			ovf_q               <= 1'b0;
			cap_q               <= 1'b0;
			dir_q               <= DIR_UP;
			pre_q               <= '0;
			ext_prev_q          <= 1'b0;
			cap_prev_q          <= 1'b0;
		end else if (ce) begin
			bus_q               <= bus_d;
			hrdata_q            <= hrdata_d;
			hready_q            <= hready_d;
			waveform_mode_low_q <= waveform_mode_low_d;
			ctrl_b_q            <= ctrl_b_d;
			cnt_q               <= cnt_d;
			cmp_a_buf_q         <= cmp_a_buf_d;
			cmp_b_buf_q         <= cmp_b_buf_d;
			cmp_a_q             <= cmp_a_d;
			cmp_b_q             <= cmp_b_d;
			capture_register_q  <= capture_register_d;
			ovf_q               <= ovf_d;
			cap_q               <= cap_d;
			dir_q               <= dir_d;
			pre_q               <= pre_d;
			ext_prev_q          <= ext_prev_d;
			cap_prev_q          <= cap_prev_d;
		end
	end

	// Outputs straight from flip-flops; hresp tied to OKAY
	assign hrdata        = hrdata_q;
	assign hreadyout     = hready_q;
	assign hresp         = 1'b0;
	assign overflow_flag = ovf_q;
	assign capture_flag  = cap_q;

	default clocking cb_main @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_normal_ovf;
		(ce && tick && waveform_mode == MODE_NORMAL && cnt_q == TOP_MAX
			&& !wr_cnt) |=> (ovf_q && cnt_q == CNT_BOTTOM);
	endproperty
	a_normal_ovf: assert property (p_normal_ovf)
		else $error("normal mode did not wrap with overflow at MAX");

	property p_pc8_turn;
		(ce && tick && waveform_mode == MODE_PC8 && dir_q == DIR_UP
			&& cnt_q == TOP_8BIT && !wr_cnt) |=>
			(dir_q == DIR_DOWN && cnt_q == TOP_8BIT - CNT_ONE);
	endproperty
	a_pc8_turn: assert property (p_pc8_turn)
		else $error("8-bit phase correct did not turn at its TOP");

	property p_fast_top;
		(ce && tick && ovf_at == EV_TOP && at_top && !wr_cnt) |=>
			(cnt_q == CNT_BOTTOM && ovf_q);
	endproperty
	a_fast_top: assert property (p_fast_top)
		else $error("fast PWM did not restart with overflow at TOP");

	property p_ctc_clear;
		(ce && tick && waveform_mode == MODE_CTC_CMP && cnt_q == cmp_a_q
			&& !wr_cnt) |=> cnt_q == CNT_BOTTOM;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear)
		else $error("CTC mode did not clear on compare A");

	property p_bottom_update;
		(ce && upd_at == EV_BOTTOM && !(tick && at_bot)) |=>
			$stable(cmp_a_q);
	endproperty
	a_bottom_update: assert property (p_bottom_update)
		else $error("compare A changed away from BOTTOM");

	property p_capture;
		(ce && cap_ev) |=> (cap_q && capture_register_q == $past(cnt_q));
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture did not copy counter and set flag");

	property p_cap_blocked;
		(ce && cap_top && !wr_cap) |=> $stable(capture_register_q);
	endproperty
	a_cap_blocked: assert property (p_cap_blocked)
		else $error("capture register moved while it sets TOP");

	property p_stopped;
		(ce && ctrl_b_q.clock_select == CS_STOP && !wr_cnt)
			|=> $stable(cnt_q);
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("counter moved with no clock source");

endmodule : tmr_top
`default_nettype wire

// file: tmr_pkg.sv
// Purpose: Shared constants and types for the 16-bit timer/counter block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Offsets are byte addresses; word index is haddr[4:2]
package tmr_pkg;

	// Register byte offsets
	localparam logic [7:0]  ADDR_CTRL_A  = 8'h00;
	localparam logic [7:0]  ADDR_CTRL_B  = 8'h04;
	localparam logic [7:0]  ADDR_COUNT   = 8'h08;
	localparam logic [7:0]  ADDR_CMP_A   = 8'h0C;
	localparam logic [7:0]  ADDR_CMP_B   = 8'h10;
	localparam logic [7:0]  ADDR_CAPTURE = 8'h14;
	localparam logic [7:0]  ADDR_FLAGS   = 8'h18;
	localparam int          IDX_LSB      = 2;
	localparam int          IDX_MSB      = 4;

	// Reset values
	localparam logic [7:0]  CTRL_RST     = 8'h00;
	localparam logic [15:0] WORD_RST     = 16'h0000;

	// Flag bit positions in the flags register
	localparam int          FLG_OVF      = 0;
	localparam int          FLG_CAP      = 1;

	// Counter limits
	localparam logic [15:0] CNT_BOTTOM   = 16'h0000;
	localparam logic [15:0] CNT_ONE      = 16'h0001;
	localparam logic [15:0] TOP_MAX      = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT     = 16'h00FF;
	localparam logic [15:0] TOP_9BIT     = 16'h01FF;
	localparam logic [15:0] TOP_10BIT    = 16'h03FF;

	// Prescaler tap masks: tap fires when masked bits are all one
	localparam logic [9:0]  PRE_ONE      = 10'h001;
	localparam logic [9:0]  PRE_DIV8     = 10'h007;
	localparam logic [9:0]  PRE_DIV16    = 10'h00F;
	localparam logic [9:0]  PRE_DIV32    = 10'h01F;
	localparam logic [9:0]  PRE_DIV64    = 10'h03F;
	localparam logic [9:0]  PRE_DIV256   = 10'h0FF;
	localparam logic [9:0]  PRE_DIV1024  = 10'h3FF;

	// Samples the capture noise filter needs
	localparam int          FILTER_SAMPLES = 4;

	// Control byte B field layout, bit 7 down to bit 0
	typedef struct packed {
		logic       noise_en;
		logic       edge_rise;
		logic       rsvd;
		logic [1:0] waveform_mode_high;
		logic [2:0] clock_select;
	} tmr_ctrl_b_type;

	// Registered address phase of a bus transfer
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       ok;
		logic [2:0] idx;
	} tmr_bus_type;

	typedef enum logic [3:0] {
		MODE_NORMAL   = 4'h0, MODE_PC8      = 4'h1,
		MODE_PC9      = 4'h2, MODE_PC10     = 4'h3,
		MODE_CTC_CMP  = 4'h4, MODE_FAST8    = 4'h5,
		MODE_FAST9    = 4'h6, MODE_FAST10   = 4'h7,
		MODE_PFC_CAP  = 4'h8, MODE_PFC_CMP  = 4'h9,
		MODE_PC_CAP   = 4'hA, MODE_PC_CMP   = 4'hB,
		MODE_CTC_CAP  = 4'hC, MODE_RESERVED = 4'hD,
		MODE_FAST_CAP = 4'hE, MODE_FAST_CMP = 4'hF
	} tmr_mode_type;

	typedef enum logic [2:0] {
		CS_STOP  = 3'h0, CS_DIV1    = 3'h1, CS_DIV8    = 3'h2,
		CS_DIV64 = 3'h3, CS_DIV256  = 3'h4, CS_DIV1024 = 3'h5,
		CS_ALT6  = 3'h6, CS_ALT7    = 3'h7
	} tmr_clk_sel_type;

	// Moment at which an update or flag happens
	typedef enum logic [1:0] {
		EV_NOW = 2'h0, EV_MAX = 2'h1, EV_TOP = 2'h3, EV_BOTTOM = 2'h2
	} tmr_event_type;

	typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} tmr_dir_type;

endpackage : tmr_pkg

// file: tmr_sync_filter.sv
// Purpose: Two-stage synchroniser with optional four-sample filter
// Assumes: Pin is asynchronous to hclk
// Notes:   Filter adds four cycles of delay when enabled
`timescale 1ns/100ps
`default_nettype none
module tmr_sync_filter (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic ce,
	input  wire logic pin,
	input  wire logic filter_en,
	output logic      level
);
	import tmr_pkg::*;

	logic                      sync1_q, sync1_d;
	logic                      sync2_q, sync2_d;
	logic [FILTER_SAMPLES-1:0] hist_q, hist_d;
	logic                      level_q, level_d;

	// Shift samples and decide the filtered level
	always_comb begin
		sync1_d = pin;
		sync2_d = sync1_q;
		hist_d  = {hist_q[FILTER_SAMPLES-2:0], sync2_q};
		level_d = level_q;
		if (!filter_en) begin
			level_d = sync2_q;
		end else if (&hist_q || ~|hist_q) begin
			level_d = hist_q[0];
		end
	end

	// Register stage, frozen while ce is low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			hist_q  <= '0;
			level_q <= 1'b0;
		end else if (ce) begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			hist_q  <= hist_d;
			level_q <= level_d;
		end
	end

	assign level = level_q;

	property p_filter_hold;
		@(posedge hclk) disable iff (!hresetn)
		(ce && filter_en && level_q != hist_q[0]) |=>
			(level_q == $past(level_q)) || (&$past(hist_q)) ||
			(~|$past(hist_q));
	endproperty
	a_filter_hold: assert property (p_filter_hold)
		else $error("filtered level changed without four equal samples");

endmodule : tmr_sync_filter
`default_nettype wire

// file: tmr_pins_model.sv
// Purpose: Far-side model driving the capture and external clock pins
// Assumes: Pins are driven push-pull, no pull resistors
// Notes:   Levels change by non-blocking assignment just after an edge
`timescale 1ns/100ps
`default_nettype none
module tmr_pins_model (
	input  wire logic hclk,
	output var logic  capture_pin,
	output var logic  external_clock_pin
);
	// Idle levels: capture high, count clock low
	initial begin
		capture_pin <= 1'b1;
		external_clock_pin <= 1'b0;
	end
	// Capture level change after an edge, returns one edge later
	task automatic set_cap(input logic v);
		@(posedge hclk);
		capture_pin <= v;
		@(posedge hclk);
	endtask : set_cap
	// Count clock driven as an output by this side
	task automatic set_ext(input logic v);
		@(posedge hclk);
		external_clock_pin <= v;
		@(posedge hclk);
	endtask : set_ext
	// Low pulse lasting n clock periods
	task automatic pulse_cap(input int n);
		@(posedge hclk);
		capture_pin <= 1'b0;
		repeat (n) @(posedge hclk);
		capture_pin <= 1'b1;
		@(posedge hclk);
	endtask : pulse_cap
endmodule : tmr_pins_model
`default_nettype wire

// file: timer16_mode_clock_capture_tb.sv
// Purpose: Self-checking bench for the timer control block
// Assumes: Both timer builds share one bus; bench is AHB-Lite master
// Notes:   Pin activity comes from the partner model
`timescale 1ns/100ps
`default_nettype none
module timer16_mode_clock_capture_tb;
	import tmr_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic        ce = 1'b1;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] hrdata3;
	logic [31:0] rd3;
	logic [31:0] c3;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        cap_pin;
	logic        ext_pin;
	logic        ovf;
	logic        capf;
	int          failures = 0;
	int          comparisons = 0;
	logic [31:0] rd;
	logic [31:0] c0;

	// Clock at 10 MHz
	always #50 hclk = ~hclk;

	tmr_top #(.SECOND_TIMER(1'b0)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.capture_pin(cap_pin), .external_clock_pin(ext_pin),
		.overflow_flag(ovf), .capture_flag(capf)
	);

	// Second timer build on the same bus, read data kept apart
	tmr_top #(.SECOND_TIMER(1'b1)) u_dut3 (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata3), .hreadyout(), .hresp(),
		.capture_pin(cap_pin), .external_clock_pin(ext_pin),
		.overflow_flag(), .capture_flag()
	);

	tmr_pins_model u_pins (
		.hclk(hclk), .capture_pin(cap_pin), .external_clock_pin(ext_pin)
	);

	// Compare and count
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic settle(input int n);
		repeat (n) @(posedge hclk);
	endtask : settle

	// Wait for hready at an edge, bounded
	task automatic wait_ready();
		for (int n = 0; n < 20; n++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) break;
		end
		if (hreadyout !== 1'b1) begin
			check("hready", 32'(hreadyout), 32'h0000_0001);
		end
	endtask : wait_ready

	// One single word transfer, entered right after an edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_ready();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		rd3 = hrdata3;
	endtask : bus

	task automatic test_regs();
		bus(0, ADDR_CTRL_B, '0);
		check("ctrl_b reset", rd, '0);
		bus(0, ADDR_CTRL_A, '0);
		check("ctrl_a reset", rd, '0);
		bus(1, ADDR_CTRL_A, 32'h0000_0003);
		bus(1, ADDR_CTRL_B, 32'h0000_00DB);
		bus(0, ADDR_CTRL_B, '0);
		check("ctrl_b", rd, 32'h0000_00DB);
		bus(0, ADDR_CTRL_A, '0);
		check("ctrl_a", rd, 32'h0000_0003);
		bus(1, ADDR_CTRL_A, '0);
		bus(1, ADDR_CTRL_B, '0);
		bus(0, 8'h1C, '0);
		check("unmapped", rd, '0);
		check("hresp", 32'(hresp), '0);
		$display("test regs done");
	endtask : test_regs

	// Each tap gives ten ticks over ten of its periods
	task automatic test_prescale();
		int div[8] = '{1, 1, 8, 64, 256, 1024, 16, 32};
		for (int cs = 0; cs < 8; cs++) begin
			bus(1, ADDR_CTRL_B, 32'(cs));
			bus(0, ADDR_COUNT, '0);
			c0 = rd;
			c3 = rd3;
			settle(div[cs] * 10 - 3);
			bus(0, ADDR_COUNT, '0);
			check("ticks", rd - c0,
				(cs == 0 || cs > 5) ? '0 : 32'h0000_000A);
			check("ticks3", rd3 - c3,
				(cs == 0) ? '0 : 32'h0000_000A);
		end
		$display("test prescale done");
	endtask : test_prescale

	task automatic test_ext();
		for (int k = 0; k < 2; k++) begin
			bus(1, ADDR_CTRL_B, 32'(7 - k));
			bus(1, ADDR_COUNT, '0);
			u_pins.set_ext(1'b1);
			settle(6);
			bus(0, ADDR_COUNT, '0);
			check("ext rise", rd, 32'(1 - k));
			u_pins.set_ext(1'b0);
			settle(6);
			bus(0, ADDR_COUNT, '0);
			check("ext fall", rd, 32'h0000_0001);
		end
		$display("test ext done");
	endtask : test_ext

	task automatic test_edge();
		bus(1, ADDR_CTRL_B, 32'h0000_0040);
		bus(1, ADDR_COUNT, 32'h0000_0ABC);
		bus(1, ADDR_FLAGS, 32'h0000_0003);
		u_pins.set_cap(1'b0);
		settle(8);
		check("fall ignored", 32'(capf), '0);
		u_pins.set_cap(1'b1);
		settle(8);
		check("rise capture", 32'(capf), 32'h0000_0001);
		bus(0, ADDR_CAPTURE, '0);
		check("capture value", rd, 32'h0000_0ABC);
		bus(1, ADDR_CTRL_B, '0);
		bus(1, ADDR_FLAGS, 32'h0000_0003);
		settle(2);
		check("flag clear", 32'(capf), '0);
		u_pins.set_cap(1'b0);
		settle(8);
		check("fall capture", 32'(capf), 32'h0000_0001);
		u_pins.set_cap(1'b1);
		$display("test edge done");
	endtask : test_edge

	// Glitch rejection and the extra latency of the filter
	task automatic test_filter();
		for (int f = 0; f < 2; f++) begin
			bus(1, ADDR_CTRL_B, f ? 32'h0000_0081 : 32'h0000_0001);
			bus(1, ADDR_FLAGS, 32'h0000_0003);
			u_pins.pulse_cap(3);
			settle(10);
			check("glitch", 32'(capf), 32'(1 - f));
			bus(1, ADDR_FLAGS, 32'h0000_0003);
			bus(1, ADDR_COUNT, '0);
			u_pins.pulse_cap(8);
			settle(12);
			bus(0, ADDR_CAPTURE, '0);
			if (f == 0) c0 = rd;
			else check("filter delay", rd, c0 + 32'h0000_0004);
		end
		$display("test filter done");
	endtask : test_filter

	task automatic test_suppress();
		for (int m = 8; m < 16; m++) begin
			bus(1, ADDR_CTRL_A, 32'(m % 4));
			bus(1, ADDR_CTRL_B, 32'((m / 4) << 3));
			bus(1, ADDR_FLAGS, 32'h0000_0003);
			u_pins.pulse_cap(6);
			settle(10);
			check("capture gate", 32'(capf), 32'(m % 2));
		end
		$display("test suppress done");
	endtask : test_suppress

	// Overflow placement near TOP, then clear-on-match wrap
	task automatic test_modes();
		int          mode[8] = '{0, 13, 5, 6, 7, 1, 2, 3};
		logic [15:0] top[8] = '{TOP_MAX, TOP_MAX, TOP_8BIT, TOP_9BIT,
			TOP_10BIT, TOP_8BIT, TOP_9BIT, TOP_10BIT};
		for (int i = 0; i < 8; i++) begin
			bus(1, ADDR_CTRL_A, 32'(mode[i] % 4));
			bus(1, ADDR_CTRL_B, 32'((mode[i] / 4) << 3));
			bus(1, ADDR_COUNT, 32'(top[i] - 16'h0003));
			bus(1, ADDR_FLAGS, 32'h0000_0003);
			bus(1, ADDR_CTRL_B, 32'(((mode[i] / 4) << 3) + 1));
			settle(20);
			check("overflow", 32'(ovf), 32'(i < 5));
			bus(1, ADDR_CTRL_B, '0);
		end
		bus(1, ADDR_CTRL_A, '0);
		bus(1, ADDR_CTRL_B, 32'h0000_0008);
		bus(1, ADDR_CMP_A, 32'h0000_0010);
		bus(1, ADDR_COUNT, 32'h0000_000C);
		bus(1, ADDR_FLAGS, 32'h0000_0003);
		bus(1, ADDR_CTRL_B, 32'h0000_0009);
		settle(40);
		bus(0, ADDR_COUNT, '0);
		check("ctc wrap", rd, 32'h0000_0002);
		check("ctc flag", 32'(ovf), '0);
		bus(1, ADDR_CTRL_B, '0);
		$display("test modes done");
	endtask : test_modes

	// Clock enable low holds the counter for ten cycles
	task automatic test_freeze();
		bus(1, ADDR_CTRL_B, 32'h0000_0001);
		bus(1, ADDR_COUNT, '0);
		ce <= 1'b0;
		settle(10);
		ce <= 1'b1;
		bus(0, ADDR_COUNT, '0);
		check("freeze", rd, 32'h0000_0001);
		bus(1, ADDR_CTRL_B, '0);
		$display("test freeze done");
	endtask : test_freeze

	task automatic tally_and_finish();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish

	// Watchdog well beyond the expected run length
	initial begin
		#(40000 * 100);
		failures++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		test_regs();
		test_prescale();
		test_ext();
		test_edge();
		test_filter();
		test_suppress();
		test_modes();
		test_freeze();
		tally_and_finish();
	end
endmodule : timer16_mode_clock_capture_tb
`default_nettype wire
